// ### dv/rem_bank_props.sv
// assertion checker for the energy status bank
`timescale 1ns/10ps
module rem_bank_props
(
  input wire logic                i_clock,
  input wire logic                i_rstn,
  input wire logic                i_rd_en,
  input wire logic [7:0]          i_rd_addr,
  input wire logic [15:0]         o_rd_data,
  input wire logic                o_rd_valid,
  input wire rem_pkg::rem_incr_t  i_incr,
  input wire rem_pkg::rem_pulse_t i_active_pulse_out,
  input wire rem_pkg::rem_pulse_t i_reactive_pulse_out,
  input wire logic                i_reactive_noload,
  input wire logic                i_active_noload,
  input wire logic                i_live_power_larger,
  input wire logic                i_flex_line_choice,
  input wire logic                i_mode_strap_hi,
  input wire logic                i_mode_strap_lo,
  input wire logic [15:0]         o_metering_status_word
);
  logic [15:0] st;
  logic        line_q;
  assign st = o_metering_status_word;

  // expected metered line from the shown mode
  always_ff @(posedge i_clock)
  begin
    line_q <= (st[1:0] == 2'h0) ? i_live_power_larger :
              (st[1:0] == 2'h3) ? i_flex_line_choice : 1'b1;
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  a_read_valid: assert property (
    i_rd_en |=> o_rd_valid) else $error("valid missing");
  a_valid_cause: assert property (
    o_rd_valid |-> $past(i_rd_en)) else $error("stray valid");
  a_rsvd_zero: assert property (
    st[10:2] == 9'h000) else $error("reserved bits set");
  a_mode_mirror: assert property (
    $past(i_rstn) |-> st[1:0] == $past({i_mode_strap_hi, i_mode_strap_lo}))
    else $error("mode bits wrong");
  a_noload_flags: assert property (
    $past(i_rstn) |->
    st[15:14] == $past({i_reactive_noload, i_active_noload}))
    else $error("noload bits wrong");
  a_react_dir: assert property (
    $past(i_rstn) |-> st[13] == ($past(i_reactive_pulse_out.abs_cfg) ? 1'b0
    : $past(i_reactive_pulse_out.pulse) ?
    $past(i_reactive_pulse_out.reverse) : $past(st[13])))
    else $error("reactive direction wrong");
  a_act_dir: assert property (
    $past(i_rstn) |-> st[12] == ($past(i_active_pulse_out.abs_cfg) ? 1'b0
    : $past(i_active_pulse_out.pulse) ?
    $past(i_active_pulse_out.reverse) : $past(st[12])))
    else $error("active direction wrong");
  a_line_sel: assert property (
    $past(i_rstn) |-> st[11] == line_q) else $error("line bit wrong");
endmodule

bind rem_bank rem_bank_props u_props (
  .i_clock(i_clock), .i_rstn(i_rstn), .i_rd_en(i_rd_en),
  .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
  .i_incr(i_incr), .i_active_pulse_out(i_active_pulse_out),
  .i_reactive_pulse_out(i_reactive_pulse_out),
  .i_reactive_noload(i_reactive_noload),
  .i_active_noload(i_active_noload),
  .i_live_power_larger(i_live_power_larger),
  .i_flex_line_choice(i_flex_line_choice),
  .i_mode_strap_hi(i_mode_strap_hi), .i_mode_strap_lo(i_mode_strap_lo),
  .o_metering_status_word(o_metering_status_word));

// ### dv/rem_bank_tb.sv
// self-checking bench for the energy status bank
`timescale 1ns/10ps
module rem_bank_tb;
  logic                clk, rstn, rd_en, rd_valid;
  logic                hi, lo, live, flex, qnl, pnl, ln;
  logic [1:0]          m;
  logic [7:0]          rd_addr;
  logic [15:0]         rd_data, status;
  rem_pkg::rem_incr_t  incr;
  rem_pkg::rem_pulse_t ap, rp;
  int                  err_count, n_checks, i;

  rem_bank u_rem_bank (
    .i_clock(clk), .i_rstn(rstn), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .i_incr(incr),
    .i_active_pulse_out(ap), .i_reactive_pulse_out(rp),
    .i_reactive_noload(qnl), .i_active_noload(pnl),
    .i_live_power_larger(live), .i_flex_line_choice(flex),
    .i_mode_strap_hi(hi), .i_mode_strap_lo(lo),
    .o_metering_status_word(status));

  rem_host u_rem_host (
    .i_clock(clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_rd_en(rd_en), .o_rd_addr(rd_addr));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        v;
    u_rem_host.read(a, d, v);
    chk({15'h0000, v}, 16'h0001);
    chk(d, exp);
  endtask

  task automatic pulse(input logic [2:0] a, input logic [2:0] q);
    @(posedge clk);
    #1;
    ap = a;
    rp = q;
    @(posedge clk);
    #1;
    ap.pulse = 1'b0;
    rp.pulse = 1'b0;
  endtask

  initial
  begin
    #4_000_000;
    err_count++;
    end_sim();
  end

  initial
  begin
    err_count = 0;
    n_checks = 0;
    rstn = 1'b0;
    incr = 5'h00;
    ap = 3'h0;
    rp = 3'h0;
    {qnl, pnl, live, flex, hi, lo} = 6'h38;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    rd(8'h46, 16'hc800);
    for (i = 0; i < 5; i++)
      rd(8'h41 + 8'(i), 16'h0000);
    rd(8'h47, 16'h0000);
    // distinct counts per counter
    for (i = 0; i < 5; i++)
    begin
      @(posedge clk);
      #1 incr = 5'(5'h1f << i);
    end
    @(posedge clk);
    #1 incr = 5'h00;
    for (i = 0; i < 10; i++)
      rd(8'h41 + 8'((i + 2) % 5), i < 5 ? 16'(5 - i) : 16'h0000);
    @(posedge clk);
    #1 incr = 5'h10;
    rd(8'h43, 16'h0001);
    incr = 5'h00;
    rd(8'h43, 16'h0001);
    @(posedge clk);
    #1 incr = 5'h08;
    repeat (65538) @(posedge clk);
    #1 incr = 5'h00;
    rd(8'h44, 16'h0002);
    pulse(3'b100, 3'b110);
    rd(8'h46, 16'he800);
    pulse(3'b110, 3'b111);
    rd(8'h46, 16'hd800);
    pulse(3'b111, 3'b100);
    rd(8'h46, 16'hc800);
    ap = 3'h0;
    rp = 3'h0;
    for (i = 0; i < 8; i++)
    begin
      {hi, lo, live} = 3'(i);
      flex = ~live;
      qnl = live;
      pnl = ~live;
      repeat (3) @(posedge clk);
      #1;
      m = {hi, lo};
      ln = (m == 2'h0) ? live : (m == 2'h3) ? flex : 1'b1;
      rd(8'h46, {qnl, pnl, 2'b00, ln, 9'h000, m});
      chk(status, {qnl, pnl, 2'b00, ln, 9'h000, m});
    end
    end_sim();
  end
endmodule

// ### dv/rem_host.sv
// host side model issuing register reads
`timescale 1ns/10ps
module rem_host
(
  input  wire logic        i_clock,
  input  wire logic        i_rd_valid,
  input  wire logic [15:0] i_rd_data,
  output logic             o_rd_en,
  output logic [7:0]       o_rd_addr
);
  initial
  begin
    o_rd_en   = 1'b0;
    o_rd_addr = 8'h00;
  end

  // one read, address released to its inverse
  task automatic read(input logic [7:0] a, output logic [15:0] d,
                      output logic v);
    @(posedge i_clock);
    #1;
    o_rd_en   = 1'b1;
    o_rd_addr = a;
    @(posedge i_clock);
    #1;
    o_rd_en   = 1'b0;
    o_rd_addr = ~a;
    v         = i_rd_valid;
    d         = i_rd_data;
  endtask
endmodule

// ### verilog/rem_accum.sv
// clear-on-read tenth-pulse energy accumulator
`timescale 1ns/10ps
module rem_accum
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_inc,
  input  wire logic        i_clear,
  output logic [15:0]      o_count
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rem_pkg::rem_accum_t state_q;
  rem_pkg::rem_accum_t state_d;

  always_comb
  begin
    state_d = state_q;
    if (i_clear)
    begin
      state_d.count = rem_pkg::REM_ACCUM_RESET;
    end
    if (i_inc)
    begin
      // wraps past all ones, no saturation
      state_d.count = state_d.count + rem_pkg::REM_ACCUM_STEP;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      state_q.count <= rem_pkg::REM_ACCUM_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign o_count = state_q.count;

endmodule

// ### verilog/rem_bank.sv
// reactive and active energy accumulators and metering status register bank
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/10ps
module rem_bank
(
  input  wire logic                i_clock,
  input  wire logic                i_rstn,
  input  wire logic                i_rd_en,
  input  wire logic [7:0]          i_rd_addr,
  output logic [15:0]              o_rd_data,
  output logic                     o_rd_valid,
  input  wire rem_pkg::rem_incr_t  i_incr,
  input  wire rem_pkg::rem_pulse_t i_active_pulse_out,
  input  wire rem_pkg::rem_pulse_t i_reactive_pulse_out,
  input  wire logic                i_reactive_noload,
  input  wire logic                i_active_noload,
  input  wire logic                i_live_power_larger,
  input  wire logic                i_flex_line_choice,
  input  wire logic                i_mode_strap_hi,
  input  wire logic                i_mode_strap_lo,
  output logic [15:0]              o_metering_status_word
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  logic hit_fwd_react;
  logic hit_rev_react;
  logic hit_abs_react;
  logic hit_rev_act;
  logic hit_abs_act;
  logic hit_status;

  assign hit_fwd_react = i_rd_en
                       && (i_rd_addr == rem_pkg::REM_ADDR_FWD_REACTIVE);
  assign hit_rev_react = i_rd_en
                       && (i_rd_addr == rem_pkg::REM_ADDR_REV_REACTIVE);
  assign hit_abs_react = i_rd_en
                       && (i_rd_addr == rem_pkg::REM_ADDR_ABS_REACTIVE);
  assign hit_rev_act   = i_rd_en
                       && (i_rd_addr == rem_pkg::REM_ADDR_REV_ACTIVE);
  assign hit_abs_act   = i_rd_en
                       && (i_rd_addr == rem_pkg::REM_ADDR_ABS_ACTIVE);
  assign hit_status    = i_rd_en
                       && (i_rd_addr == rem_pkg::REM_ADDR_STATUS);

  // ---------------------------------------------------------------
  // energy accumulators
  // ---------------------------------------------------------------
  logic [15:0] fwd_reactive_accum;
  logic [15:0] rev_reactive_accum;
  logic [15:0] abs_reactive_accum;
  logic [15:0] rev_active_accum;
  logic [15:0] abs_active_accum;

  // each increment is a tenth of an output pulse
  rem_accum u_fwd_reactive
  (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_inc   (i_incr.fwd_reactive),
    .i_clear (hit_fwd_react),
    .o_count (fwd_reactive_accum)
  );

  rem_accum u_rev_reactive
  (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_inc   (i_incr.rev_reactive),
    .i_clear (hit_rev_react),
    .o_count (rev_reactive_accum)
  );

  rem_accum u_abs_reactive
  (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_inc   (i_incr.abs_reactive),
    .i_clear (hit_abs_react),
    .o_count (abs_reactive_accum)
  );

  rem_accum u_rev_active
  (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_inc   (i_incr.rev_active),
    .i_clear (hit_rev_act),
    .o_count (rev_active_accum)
  );

  rem_accum u_abs_active
  (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_inc   (i_incr.abs_active),
    .i_clear (hit_abs_act),
    .o_count (abs_active_accum)
  );

  // ---------------------------------------------------------------
  // core state
  // ---------------------------------------------------------------
  rem_pkg::rem_core_t state_q;
  rem_pkg::rem_core_t state_d;
  logic [15:0]        status_word;
  logic [15:0]        read_mux;

  // ---------------------------------------------------------------
  // status word assembly
  // ---------------------------------------------------------------
  always_comb
  begin
    status_word = 16'h0000;
    status_word[rem_pkg::REM_BIT_REACT_NOLOAD] = state_q.react_noload;
    status_word[rem_pkg::REM_BIT_ACT_NOLOAD]   = state_q.act_noload;
    status_word[rem_pkg::REM_BIT_REACT_REV]    = state_q.react_rev;
    status_word[rem_pkg::REM_BIT_ACT_REV]      = state_q.act_rev;
    status_word[rem_pkg::REM_BIT_LINE_LIVE]    = state_q.line_live;
    status_word[rem_pkg::REM_BIT_MODE_LSB +: 2] = state_q.mode;
  end

  // ---------------------------------------------------------------
  // read data select
  // ---------------------------------------------------------------
  always_comb
  begin
    case (i_rd_addr)
      rem_pkg::REM_ADDR_REV_ACTIVE:   read_mux = rev_active_accum;
      rem_pkg::REM_ADDR_ABS_ACTIVE:   read_mux = abs_active_accum;
      rem_pkg::REM_ADDR_FWD_REACTIVE: read_mux = fwd_reactive_accum;
      rem_pkg::REM_ADDR_REV_REACTIVE: read_mux = rev_reactive_accum;
      rem_pkg::REM_ADDR_ABS_REACTIVE: read_mux = abs_reactive_accum;
      rem_pkg::REM_ADDR_STATUS:       read_mux = status_word;
      default:                        read_mux = rem_pkg::REM_UNMAPPED;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;

    // read captures the value present before the clear
    state_d.rd_valid = i_rd_en;
    if (i_rd_en)
    begin
      state_d.rd_data = read_mux;
    end

    // no-load levels
    state_d.react_noload = i_reactive_noload;
    state_d.act_noload   = i_active_noload;

    // last reactive pulse direction
    if (i_reactive_pulse_out.pulse)
    begin
      state_d.react_rev = i_reactive_pulse_out.reverse;
    end
    if (i_reactive_pulse_out.abs_cfg)
    begin
      state_d.react_rev = 1'b0;
    end

    // last active pulse direction
    if (i_active_pulse_out.pulse)
    begin
      state_d.act_rev = i_active_pulse_out.reverse;
    end
    if (i_active_pulse_out.abs_cfg)
    begin
      state_d.act_rev = 1'b0;
    end

    // strap pins mirrored
    state_d.mode = {i_mode_strap_hi, i_mode_strap_lo};

    // metered line by mode
    case (state_q.mode)
      rem_pkg::REM_MODE_ANTI_TAMPER:
      begin
        state_d.line_live = i_live_power_larger;
      end
      rem_pkg::REM_MODE_FIXED_LIVE:
      begin
        state_d.line_live = 1'b1;
      end
      rem_pkg::REM_MODE_LIVE_NEUTRAL:
      begin
        state_d.line_live = 1'b1;
      end
      rem_pkg::REM_MODE_FLEXIBLE:
      begin
        state_d.line_live = i_flex_line_choice;
      end
      default:
      begin
        state_d.line_live = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    if (!i_rstn)
    begin
      state_q.rd_data      <= rem_pkg::REM_ACCUM_RESET;
      state_q.rd_valid     <= 1'b0;
      state_q.react_noload <=
        rem_pkg::REM_STATUS_RESET[rem_pkg::REM_BIT_REACT_NOLOAD];
      state_q.act_noload   <=
        rem_pkg::REM_STATUS_RESET[rem_pkg::REM_BIT_ACT_NOLOAD];
      state_q.react_rev    <=
        rem_pkg::REM_STATUS_RESET[rem_pkg::REM_BIT_REACT_REV];
      state_q.act_rev      <=
        rem_pkg::REM_STATUS_RESET[rem_pkg::REM_BIT_ACT_REV];
      state_q.line_live    <=
        rem_pkg::REM_STATUS_RESET[rem_pkg::REM_BIT_LINE_LIVE];
      state_q.mode         <=
        rem_pkg::REM_STATUS_RESET[rem_pkg::REM_BIT_MODE_LSB +: 2];
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_rd_data              = state_q.rd_data;
  assign o_rd_valid             = state_q.rd_valid;
  assign o_metering_status_word = status_word;

endmodule

// ### verilog/rem_pkg.sv
// shared constants and types for the reactive and active energy status bank
package rem_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] REM_ADDR_REV_ACTIVE   = 8'h41;
  localparam logic [7:0] REM_ADDR_ABS_ACTIVE   = 8'h42;
  localparam logic [7:0] REM_ADDR_FWD_REACTIVE = 8'h43;
  localparam logic [7:0] REM_ADDR_REV_REACTIVE = 8'h44;
  localparam logic [7:0] REM_ADDR_ABS_REACTIVE = 8'h45;
  localparam logic [7:0] REM_ADDR_STATUS       = 8'h46;

  // ---------------------------------------------------------------
  // reset, unmapped read and increment step values
  // ---------------------------------------------------------------
  localparam logic [15:0] REM_ACCUM_RESET  = 16'h0000;
  localparam logic [15:0] REM_STATUS_RESET = 16'hc800;
  localparam logic [15:0] REM_UNMAPPED     = 16'h0000;
  localparam logic [15:0] REM_ACCUM_STEP   = 16'h0001;

  // ---------------------------------------------------------------
  // status field positions
  // ---------------------------------------------------------------
  localparam int REM_BIT_REACT_NOLOAD = 15;
  localparam int REM_BIT_ACT_NOLOAD   = 14;
  localparam int REM_BIT_REACT_REV    = 13;
  localparam int REM_BIT_ACT_REV      = 12;
  localparam int REM_BIT_LINE_LIVE    = 11;
  localparam int REM_BIT_MODE_LSB     = 0;

  // ---------------------------------------------------------------
  // line mode strap encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] REM_MODE_ANTI_TAMPER  = 2'h0;
  localparam logic [1:0] REM_MODE_FIXED_LIVE   = 2'h1;
  localparam logic [1:0] REM_MODE_LIVE_NEUTRAL = 2'h2;
  localparam logic [1:0] REM_MODE_FLEXIBLE     = 2'h3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic fwd_reactive;
    logic rev_reactive;
    logic abs_reactive;
    logic rev_active;
    logic abs_active;
  } rem_incr_t;

  typedef struct packed {
    logic pulse;
    logic reverse;
    logic abs_cfg;
  } rem_pulse_t;

  typedef struct packed {
    logic [15:0] count;
  } rem_accum_t;

  typedef struct packed {
    logic [15:0] rd_data;
    logic        rd_valid;
    logic        react_noload;
    logic        act_noload;
    logic        react_rev;
    logic        act_rev;
    logic        line_live;
    logic [1:0]  mode;
  } rem_core_t;

endpackage
